// >>> rtl/aws_pkg.sv
// Package for the working-register set: widths, depths, reset values and
// the microinstruction field encodings shared by all design files.
// Assumes a single processor clock and control logic that drives the fields.
package aws_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int REG_COUNT = 6;
	localparam int BIG_DEPTH = 256;
	localparam int BIG_AW = 8;
	localparam int LIT_DEPTH = 32;
	localparam int LIT_AW = 5;
	localparam int PTR_W = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [BIG_AW-1:0] ADDR_RST = 8'h00;

	// ----------------------------------------------------------------
	// Function control word locations inside the small file
	// ----------------------------------------------------------------
	localparam logic [LIT_AW-1:0] FCW_LO_ADDR = 5'h1e;
	localparam logic [LIT_AW-1:0] FCW_HI_ADDR = 5'h1f;

	// ----------------------------------------------------------------
	// Microinstruction field encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		AWS_OP_ADD,
		AWS_OP_SUB,
		AWS_OP_INC_A,
		AWS_OP_PASS_A,
		AWS_OP_PASS_B,
		AWS_OP_AND,
		AWS_OP_OR,
		AWS_OP_XOR
	} aws_op_t;

	typedef enum logic [2:0] {
		AWS_S1_BUS,
		AWS_S1_CAPTURE,
		AWS_S1_COUNTER,
		AWS_S1_SHIFT_STORE,
		AWS_S1_STORE_ENTRY,
		AWS_S1_HOLD,
		AWS_S1_BIG_FILE,
		AWS_S1_LIT_FILE
	} aws_sel1_t;

	typedef enum logic [2:0] {
		AWS_S2_ZERO,
		AWS_S2_STORE_ENTRY,
		AWS_S2_HOLD,
		AWS_S2_SHIFT_EXT,
		AWS_S2_BIG_FILE,
		AWS_S2_LIT_FILE
	} aws_sel2_t;

	typedef enum logic [3:0] {
		AWS_DST_NONE,
		AWS_DST_CAPTURE,
		AWS_DST_COUNTER,
		AWS_DST_SHIFT_STORE,
		AWS_DST_STORE_ENTRY,
		AWS_DST_HOLD,
		AWS_DST_SHIFT_EXT,
		AWS_DST_BIG_FILE,
		AWS_DST_LIT_FILE
	} aws_dest_t;

	typedef enum logic [2:0] {
		AWS_SH_NONE,
		AWS_SH_LEFT,
		AWS_SH_RIGHT,
		AWS_SH_DBL_LEFT,
		AWS_SH_DBL_RIGHT
	} aws_shift_t;

endpackage : aws_pkg

// >>> rtl/aws_file_mem.sv
// Addressable word file with one write port and a registered read port.
// Assumes write and read addresses are stable at the clock edge.
`timescale 1ns/100ps
`default_nettype none
module aws_file_mem #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [aws_pkg::WORD_W-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output var logic [aws_pkg::WORD_W-1:0] rd_data_q
);

	logic [aws_pkg::WORD_W-1:0] mem [DEPTH];

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// Registered read
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data_q <= aws_pkg::WORD_RST;
		end
		else
		begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule : aws_file_mem
`default_nettype wire

// >>> rtl/aws_adder.sv
// Sixteen-bit combinational adder and logic unit.
// Assumes operands come from the two input selectors in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module aws_adder (
	input wire logic [aws_pkg::WORD_W-1:0] a_in,
	input wire logic [aws_pkg::WORD_W-1:0] b_in,
	input wire aws_pkg::aws_op_t op,
	output logic [aws_pkg::WORD_W-1:0] sum,
	output logic carry_out
);

	logic [aws_pkg::WORD_W:0] wide;

	always_comb
	begin
		wide = {1'b0, aws_pkg::WORD_RST};
		unique case (op)
			aws_pkg::AWS_OP_ADD: wide = {1'b0, a_in} + {1'b0, b_in};
			aws_pkg::AWS_OP_SUB: wide = {1'b0, a_in} + {1'b0, ~b_in} + 17'h00001;
			aws_pkg::AWS_OP_INC_A: wide = {1'b0, a_in} + 17'h00001;
			aws_pkg::AWS_OP_PASS_A: wide = {1'b0, a_in};
			aws_pkg::AWS_OP_PASS_B: wide = {1'b0, b_in};
			aws_pkg::AWS_OP_AND: wide = {1'b0, a_in & b_in};
			aws_pkg::AWS_OP_OR: wide = {1'b0, a_in | b_in};
			aws_pkg::AWS_OP_XOR: wide = {1'b0, a_in ^ b_in};
		endcase
		sum = wide[aws_pkg::WORD_W-1:0];
		carry_out = wide[aws_pkg::WORD_W];
	end

endmodule : aws_adder
`default_nettype wire

// >>> rtl/aws_working_regs.sv
// Working-register set with two addressable files feeding the adder.
// Assumes the microinstruction control drives selector, destination and
// shift fields each cycle, and supplies both file pointers.
`timescale 1ns/100ps
`default_nettype none
module aws_working_regs (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [aws_pkg::WORD_W-1:0] bus_word,
	input wire logic [aws_pkg::WORD_W-1:0] xlat_word,
	input wire logic big_file_mode,
	input wire logic [aws_pkg::PTR_W-1:0] wide_ptr,
	input wire logic [aws_pkg::PTR_W-1:0] little_ptr,
	input wire aws_pkg::aws_sel1_t operand_one_select,
	input wire aws_pkg::aws_sel2_t operand_two_select,
	input wire aws_pkg::aws_op_t adder_op,
	input wire aws_pkg::aws_dest_t dest_select,
	input wire aws_pkg::aws_shift_t shift_cmd,
	input wire logic shift_fill,
	output var logic [aws_pkg::WORD_W-1:0] result_q,
	output var logic carry_q,
	output var logic zero_q,
	output var logic [aws_pkg::WORD_W-1:0] io_word_q,
	output var logic [aws_pkg::WORD_W-1:0] counter_word_q,
	output var logic [aws_pkg::WORD_W-1:0] function_control_word_lo_q,
	output var logic [aws_pkg::WORD_W-1:0] function_control_word_hi_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	// six working registers
	logic [aws_pkg::WORD_W-1:0] capture_q;
	logic [aws_pkg::WORD_W-1:0] counter_q;
	logic [aws_pkg::WORD_W-1:0] shift_store_q;
	logic [aws_pkg::WORD_W-1:0] store_entry_q;
	logic [aws_pkg::WORD_W-1:0] hold_q;
	logic [aws_pkg::WORD_W-1:0] shift_ext_q;
	logic [aws_pkg::WORD_W-1:0] operand_one_selector;
	logic [aws_pkg::WORD_W-1:0] operand_two_selector;
	logic [aws_pkg::WORD_W-1:0] result_selector;
	logic [aws_pkg::WORD_W-1:0] adder_sum;
	logic adder_carry;
	logic [aws_pkg::WORD_W-1:0] big_rd_data;
	logic [aws_pkg::WORD_W-1:0] lit_rd_data;
	logic [aws_pkg::WORD_W-1:0] big_bus;
	logic [aws_pkg::LIT_AW-1:0] lit_addr;
	logic wr_pend_q;
	logic wr_big_q;
	logic [aws_pkg::BIG_AW-1:0] wr_addr_q;
	logic big_wr_en;
	logic lit_wr_en;
	logic [aws_pkg::WORD_W*2-1:0] pair_word;

	function automatic logic dest_is(input aws_pkg::aws_dest_t d, input aws_pkg::aws_dest_t w);
		dest_is = (d == w);
	endfunction : dest_is

	// ----------------------------------------------------------------
	// File addressing
	// ----------------------------------------------------------------
	// low five bits
	assign lit_addr = little_ptr[aws_pkg::LIT_AW-1:0];

	assign big_bus = big_file_mode ? xlat_word : big_rd_data;

	// ----------------------------------------------------------------
	// Operand selectors
	// ----------------------------------------------------------------
	always_comb
	begin
		operand_one_selector = aws_pkg::WORD_RST;
		unique case (operand_one_select)
			aws_pkg::AWS_S1_BUS: operand_one_selector = bus_word;
			aws_pkg::AWS_S1_CAPTURE: operand_one_selector = capture_q;
			aws_pkg::AWS_S1_COUNTER: operand_one_selector = counter_q;
			aws_pkg::AWS_S1_SHIFT_STORE: operand_one_selector = shift_store_q;
			aws_pkg::AWS_S1_STORE_ENTRY: operand_one_selector = store_entry_q;
			aws_pkg::AWS_S1_HOLD: operand_one_selector = hold_q;
			aws_pkg::AWS_S1_BIG_FILE: operand_one_selector = big_bus;
			aws_pkg::AWS_S1_LIT_FILE: operand_one_selector = lit_rd_data;
		endcase
	end

	always_comb
	begin
		operand_two_selector = aws_pkg::WORD_RST;
		unique case (operand_two_select)
			aws_pkg::AWS_S2_ZERO: operand_two_selector = aws_pkg::WORD_RST;
			aws_pkg::AWS_S2_STORE_ENTRY: operand_two_selector = store_entry_q;
			aws_pkg::AWS_S2_HOLD: operand_two_selector = hold_q;
			aws_pkg::AWS_S2_SHIFT_EXT: operand_two_selector = shift_ext_q;
			aws_pkg::AWS_S2_BIG_FILE: operand_two_selector = big_bus;
			aws_pkg::AWS_S2_LIT_FILE: operand_two_selector = lit_rd_data;
			default: operand_two_selector = aws_pkg::WORD_RST;
		endcase
	end

	// ----------------------------------------------------------------
	// Adder and result selector
	// ----------------------------------------------------------------
	aws_adder u_adder (
		.a_in(operand_one_selector),
		.b_in(operand_two_selector),
		.op(adder_op),
		.sum(adder_sum),
		.carry_out(adder_carry)
	);

	assign result_selector = adder_sum;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			result_q <= aws_pkg::WORD_RST;
			carry_q <= 1'b0;
			zero_q <= 1'b0;
		end
		else
		begin
			result_q <= result_selector;
			carry_q <= adder_carry;
			zero_q <= (result_selector == aws_pkg::WORD_RST);
		end
	end

	// ----------------------------------------------------------------
	// Capture register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			capture_q <= aws_pkg::WORD_RST;
		end
		else if (dest_is(dest_select, aws_pkg::AWS_DST_CAPTURE))
		begin
			capture_q <= operand_one_selector;
		end
	end

	// ----------------------------------------------------------------
	// Counter, store entry and hold registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			counter_q <= aws_pkg::WORD_RST;
		end
		else if (dest_is(dest_select, aws_pkg::AWS_DST_COUNTER))
		begin
			counter_q <= result_selector;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			store_entry_q <= aws_pkg::WORD_RST;
		end
		else if (dest_is(dest_select, aws_pkg::AWS_DST_STORE_ENTRY) ||
			dest_is(dest_select, aws_pkg::AWS_DST_BIG_FILE) ||
			dest_is(dest_select, aws_pkg::AWS_DST_LIT_FILE))
		begin
			store_entry_q <= result_selector;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hold_q <= aws_pkg::WORD_RST;
		end
		else if (dest_is(dest_select, aws_pkg::AWS_DST_HOLD))
		begin
			hold_q <= result_selector;
		end
	end

	// ----------------------------------------------------------------
	// Shift store and shift extension pair
	// ----------------------------------------------------------------
	// Extension is the high half, shift store the low half
	assign pair_word = {shift_ext_q, shift_store_q};

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_store_q <= aws_pkg::WORD_RST;
		end
		else if (dest_is(dest_select, aws_pkg::AWS_DST_SHIFT_STORE))
		begin
			shift_store_q <= result_selector;
		end
		else
		begin
			unique case (shift_cmd)
				aws_pkg::AWS_SH_NONE: shift_store_q <= shift_store_q;
				aws_pkg::AWS_SH_LEFT: shift_store_q <= {shift_store_q[14:0], shift_fill};
				aws_pkg::AWS_SH_RIGHT: shift_store_q <= {shift_fill, shift_store_q[15:1]};
				aws_pkg::AWS_SH_DBL_LEFT: shift_store_q <= {shift_store_q[14:0], shift_fill};
				aws_pkg::AWS_SH_DBL_RIGHT: shift_store_q <= pair_word[16:1];
				default: shift_store_q <= shift_store_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_ext_q <= aws_pkg::WORD_RST;
		end
		else if (dest_is(dest_select, aws_pkg::AWS_DST_SHIFT_EXT))
		begin
			shift_ext_q <= result_selector;
		end
		else
		begin
			unique case (shift_cmd)
				aws_pkg::AWS_SH_DBL_LEFT: shift_ext_q <= pair_word[30:15];
				aws_pkg::AWS_SH_DBL_RIGHT: shift_ext_q <= {shift_fill, shift_ext_q[15:1]};
				default: shift_ext_q <= shift_ext_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Deferred file write from the store entry register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_q <= 1'b0;
			wr_big_q <= 1'b0;
			wr_addr_q <= aws_pkg::ADDR_RST;
		end
		else
		begin
			wr_pend_q <= dest_is(dest_select, aws_pkg::AWS_DST_BIG_FILE) ||
				dest_is(dest_select, aws_pkg::AWS_DST_LIT_FILE);
			wr_big_q <= dest_is(dest_select, aws_pkg::AWS_DST_BIG_FILE);
			wr_addr_q <= dest_is(dest_select, aws_pkg::AWS_DST_BIG_FILE) ?
				wide_ptr : {3'h0, lit_addr};
		end
	end

	assign big_wr_en = wr_pend_q && wr_big_q;
	assign lit_wr_en = wr_pend_q && !wr_big_q;

	// ----------------------------------------------------------------
	// Files
	// ----------------------------------------------------------------
	// full wide pointer
	aws_file_mem #(
		.DEPTH(aws_pkg::BIG_DEPTH),
		.AW(aws_pkg::BIG_AW)
	) u_big_file (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.wr_en(big_wr_en),
		.wr_addr(wr_addr_q),
		.wr_data(store_entry_q),
		.rd_addr(wide_ptr),
		.rd_data_q(big_rd_data)
	);

	aws_file_mem #(
		.DEPTH(aws_pkg::LIT_DEPTH),
		.AW(aws_pkg::LIT_AW)
	) u_lit_file (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.wr_en(lit_wr_en),
		.wr_addr(wr_addr_q[aws_pkg::LIT_AW-1:0]),
		.wr_data(store_entry_q),
		.rd_addr(lit_addr),
		.rd_data_q(lit_rd_data)
	);

	// ----------------------------------------------------------------
	// Function control word mirror
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			function_control_word_lo_q <= aws_pkg::WORD_RST;
			function_control_word_hi_q <= aws_pkg::WORD_RST;
		end
		else if (lit_wr_en)
		begin
			if (wr_addr_q[aws_pkg::LIT_AW-1:0] == aws_pkg::FCW_LO_ADDR)
			begin
				function_control_word_lo_q <= store_entry_q;
			end
			if (wr_addr_q[aws_pkg::LIT_AW-1:0] == aws_pkg::FCW_HI_ADDR)
			begin
				function_control_word_hi_q <= store_entry_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outward copies
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			io_word_q <= aws_pkg::WORD_RST;
			counter_word_q <= aws_pkg::WORD_RST;
		end
		else
		begin
			if (dest_is(dest_select, aws_pkg::AWS_DST_HOLD))
			begin
				io_word_q <= result_selector;
			end
			if (dest_is(dest_select, aws_pkg::AWS_DST_COUNTER))
			begin
				counter_word_q <= result_selector;
			end
		end
	end

endmodule : aws_working_regs
`default_nettype wire

// >>> verif/aws_working_regs_asserts.sv
// Port-level checker for the working-register set.
// Assumes it is bound to aws_working_regs and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module aws_working_regs_asserts (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [aws_pkg::WORD_W-1:0] bus_word,
	input wire logic [aws_pkg::PTR_W-1:0] little_ptr,
	input wire aws_pkg::aws_sel1_t operand_one_select,
	input wire aws_pkg::aws_sel2_t operand_two_select,
	input wire aws_pkg::aws_op_t adder_op,
	input wire aws_pkg::aws_dest_t dest_select,
	input wire logic [aws_pkg::WORD_W-1:0] result_q,
	input wire logic carry_q,
	input wire logic zero_q,
	input wire logic [aws_pkg::WORD_W-1:0] io_word_q,
	input wire logic [aws_pkg::WORD_W-1:0] counter_word_q,
	input wire logic [aws_pkg::WORD_W-1:0] function_control_word_lo_q,
	input wire logic [aws_pkg::WORD_W-1:0] function_control_word_hi_q
);
	logic lit_wr;
	logic lo_wr;
	logic hi_wr;
	assign lit_wr = dest_select == aws_pkg::AWS_DST_LIT_FILE;
	assign lo_wr = lit_wr && little_ptr[4:0] == aws_pkg::FCW_LO_ADDR;
	assign hi_wr = lit_wr && little_ptr[4:0] == aws_pkg::FCW_HI_ADDR;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_hold_load;
		dest_select == aws_pkg::AWS_DST_HOLD |=> io_word_q == result_q;
	endproperty
	a_hold_load: assert property (p_hold_load)
		else $error("hold copy differs from result");
	property p_io_keep;
		dest_select != aws_pkg::AWS_DST_HOLD |=> $stable(io_word_q);
	endproperty
	a_io_keep: assert property (p_io_keep)
		else $error("hold copy moved without load");
	property p_ctr_load;
		dest_select == aws_pkg::AWS_DST_COUNTER |=> counter_word_q == result_q;
	endproperty
	a_ctr_load: assert property (p_ctr_load)
		else $error("counter differs from result");
	property p_ctr_keep;
		dest_select != aws_pkg::AWS_DST_COUNTER |=> $stable(counter_word_q);
	endproperty
	a_ctr_keep: assert property (p_ctr_keep)
		else $error("counter moved without load");
	property p_bus_pass;
		operand_one_select == aws_pkg::AWS_S1_BUS && adder_op == aws_pkg::AWS_OP_PASS_A
			|=> result_q == $past(bus_word);
	endproperty
	a_bus_pass: assert property (p_bus_pass)
		else $error("bus word not passed");
	property p_zero;
		1'b1 |=> zero_q == (result_q == 16'h0000);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag wrong");
	property p_fcw_lo;
		lo_wr |=> ##1 function_control_word_lo_q == $past(result_q);
	endproperty
	a_fcw_lo: assert property (p_fcw_lo)
		else $error("low control word not written");
	property p_fcw_hi;
		$changed(function_control_word_hi_q) |-> $past(hi_wr, 2);
	endproperty
	a_fcw_hi: assert property (p_fcw_hi)
		else $error("high control word changed unasked");
	property p_inc_hold;
		operand_one_select == aws_pkg::AWS_S1_HOLD && adder_op == aws_pkg::AWS_OP_INC_A
			|=> result_q == $past(io_word_q) + 16'h0001;
	endproperty
	a_inc_hold: assert property (p_inc_hold)
		else $error("hold increment wrong");
	property p_add_ctr;
		operand_one_select == aws_pkg::AWS_S1_COUNTER && adder_op == aws_pkg::AWS_OP_ADD
			&& operand_two_select == aws_pkg::AWS_S2_ZERO
			|=> !carry_q && result_q == $past(counter_word_q);
	endproperty
	a_add_ctr: assert property (p_add_ctr)
		else $error("counter add of zero wrong");

	c_lo_wr: cover property (lo_wr ##2 1'b1);
	c_hold: cover property (dest_select == aws_pkg::AWS_DST_HOLD);
	c_inc: cover property (operand_one_select == aws_pkg::AWS_S1_HOLD
		&& adder_op == aws_pkg::AWS_OP_INC_A);
endmodule : aws_working_regs_asserts

bind aws_working_regs aws_working_regs_asserts u_aws_working_regs_asserts (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.bus_word(bus_word),
	.little_ptr(little_ptr),
	.operand_one_select(operand_one_select),
	.operand_two_select(operand_two_select),
	.adder_op(adder_op),
	.dest_select(dest_select),
	.result_q(result_q),
	.carry_q(carry_q),
	.zero_q(zero_q),
	.io_word_q(io_word_q),
	.counter_word_q(counter_word_q),
	.function_control_word_lo_q(function_control_word_lo_q),
	.function_control_word_hi_q(function_control_word_hi_q)
);
`default_nettype wire

// >>> verif/aws_ctl_model.sv
// Model of the control side: file pointer registers and the shared bus.
// Assumes the bench requests pointer loads and bus drives after the edge.
`timescale 1ns/100ps
`default_nettype none
module aws_ctl_model (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ptr_load,
	input wire logic [7:0] wide_next,
	input wire logic [7:0] little_next,
	input wire logic bus_en,
	input wire logic [15:0] bus_next,
	output var logic [7:0] wide_ptr,
	output var logic [7:0] little_ptr,
	output logic [15:0] bus_word
);
	logic [15:0] last_q;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wide_ptr <= 8'h00;
			little_ptr <= 8'h00;
		end
		else if (ptr_load)
		begin
			wide_ptr <= wide_next;
			little_ptr <= little_next;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (bus_en)
			last_q <= bus_next;
	end

	// Released bus shows the inverse of its last word
	assign bus_word = bus_en ? bus_next : ~last_q;
endmodule : aws_ctl_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for aws_working_regs with a cycle model.
// Assumes a 100 MHz clock and inputs driven 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] xlat_word = 16'h0000, bus_next = 16'h0000, bus_word;
	logic mode = 1'b0, fill = 1'b0, ptr_load = 1'b0, bus_en = 1'b1;
	logic [7:0] wide_next = 8'h00, little_next = 8'h00, wide_ptr, little_ptr;
	aws_pkg::aws_sel1_t s1 = aws_pkg::AWS_S1_BUS;
	aws_pkg::aws_sel2_t s2 = aws_pkg::AWS_S2_ZERO;
	aws_pkg::aws_op_t op = aws_pkg::AWS_OP_PASS_A;
	aws_pkg::aws_dest_t dst = aws_pkg::AWS_DST_NONE;
	aws_pkg::aws_shift_t sh = aws_pkg::AWS_SH_NONE;
	logic [15:0] res, io, ctr, lo, hi;
	logic carry, zero;
	int mismatches = 0, total_checks = 0, cycles = 0;
	logic [31:0] seed = 32'h00007ad1;
	// Model state
	logic [15:0] m_cap, m_ctr, m_ss, m_se, m_hold, m_ext, m_res, m_lo, m_hi;
	logic [15:0] m_big [256];
	logic [15:0] m_lit [32];
	logic [15:0] m_brd, m_lrd, a, b, bw, nss, next;
	logic [16:0] r;
	logic m_carry, m_zero, m_ckc, m_pb, m_pl;
	logic [7:0] m_pa;

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	aws_ctl_model u_aws_ctl_model (.sys_clk(sys_clk), .rst_b(rst_b), .ptr_load(ptr_load),
		.wide_next(wide_next), .little_next(little_next), .bus_en(bus_en),
		.bus_next(bus_next), .wide_ptr(wide_ptr), .little_ptr(little_ptr), .bus_word(bus_word));
	aws_working_regs u_aws_working_regs (.sys_clk(sys_clk), .rst_b(rst_b), .bus_word(bus_word),
		.xlat_word(xlat_word), .big_file_mode(mode), .wide_ptr(wide_ptr),
		.little_ptr(little_ptr), .operand_one_select(s1), .operand_two_select(s2),
		.adder_op(op), .dest_select(dst), .shift_cmd(sh), .shift_fill(fill), .result_q(res),
		.carry_q(carry), .zero_q(zero), .io_word_q(io), .counter_word_q(ctr),
		.function_control_word_lo_q(lo), .function_control_word_hi_q(hi));

	// ----------------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			{m_cap, m_ctr, m_ss, m_se, m_hold, m_ext, m_res, m_lo, m_hi} = '0;
			{m_carry, m_zero, m_ckc, m_pb, m_pl} = '0;
			{m_brd, m_lrd} = '0;
		end
		else
		begin
			bw = mode ? xlat_word : m_brd;
			a = s1 == aws_pkg::AWS_S1_BUS ? bus_word : s1 == aws_pkg::AWS_S1_CAPTURE ? m_cap
				: s1 == aws_pkg::AWS_S1_COUNTER ? m_ctr : s1 == aws_pkg::AWS_S1_SHIFT_STORE ? m_ss
				: s1 == aws_pkg::AWS_S1_STORE_ENTRY ? m_se : s1 == aws_pkg::AWS_S1_HOLD ? m_hold
				: s1 == aws_pkg::AWS_S1_BIG_FILE ? bw : m_lrd;
			b = s2 == aws_pkg::AWS_S2_STORE_ENTRY ? m_se : s2 == aws_pkg::AWS_S2_HOLD ? m_hold
				: s2 == aws_pkg::AWS_S2_SHIFT_EXT ? m_ext : s2 == aws_pkg::AWS_S2_BIG_FILE ? bw
				: s2 == aws_pkg::AWS_S2_LIT_FILE ? m_lrd : 16'h0000;
			case (op)
				aws_pkg::AWS_OP_ADD: r = {1'b0, a} + {1'b0, b};
				aws_pkg::AWS_OP_SUB: r = {1'b0, a} + {1'b0, ~b} + 17'h00001;
				aws_pkg::AWS_OP_INC_A: r = {1'b0, a} + 17'h00001;
				aws_pkg::AWS_OP_PASS_A: r = {1'b0, a};
				aws_pkg::AWS_OP_PASS_B: r = {1'b0, b};
				aws_pkg::AWS_OP_AND: r = {1'b0, a & b};
				aws_pkg::AWS_OP_OR: r = {1'b0, a | b};
				default: r = {1'b0, a ^ b};
			endcase
			m_res = r[15:0];
			m_carry = r[16];
			m_zero = r[15:0] == 16'h0000;
			m_ckc = op inside {aws_pkg::AWS_OP_ADD, aws_pkg::AWS_OP_SUB, aws_pkg::AWS_OP_INC_A};
			m_brd = m_big[wide_ptr];
			m_lrd = m_lit[little_ptr[4:0]];
			if (m_pb)
				m_big[m_pa] = m_se;
			if (m_pl)
				m_lit[m_pa[4:0]] = m_se;
			if (m_pl && m_pa[4:0] == aws_pkg::FCW_LO_ADDR)
				m_lo = m_se;
			if (m_pl && m_pa[4:0] == aws_pkg::FCW_HI_ADDR)
				m_hi = m_se;
			m_pb = dst == aws_pkg::AWS_DST_BIG_FILE;
			m_pl = dst == aws_pkg::AWS_DST_LIT_FILE;
			m_pa = m_pb ? wide_ptr : little_ptr;
			nss = m_ss;
			next = m_ext;
			case (sh)
				aws_pkg::AWS_SH_LEFT: nss = {m_ss[14:0], fill};
				aws_pkg::AWS_SH_RIGHT: nss = {fill, m_ss[15:1]};
				aws_pkg::AWS_SH_DBL_LEFT: {next, nss} = {m_ext[14:0], m_ss, fill};
				aws_pkg::AWS_SH_DBL_RIGHT: {next, nss} = {fill, m_ext, m_ss[15:1]};
				default: ;
			endcase
			m_ss = nss;
			m_ext = next;
			case (dst)
				aws_pkg::AWS_DST_CAPTURE: m_cap = a;
				aws_pkg::AWS_DST_COUNTER: m_ctr = m_res;
				aws_pkg::AWS_DST_SHIFT_STORE: m_ss = m_res;
				aws_pkg::AWS_DST_HOLD: m_hold = m_res;
				aws_pkg::AWS_DST_SHIFT_EXT: m_ext = m_res;
				aws_pkg::AWS_DST_NONE: ;
				default: m_se = m_res;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Comparison
	// ----------------------------------------------------------------
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask : check_bit

	always @(negedge sys_clk)
	begin
		if (rst_b)
		begin
			check_word(res, m_res, "result");
			check_bit(zero, m_zero, "zero");
			if (m_ckc)
				check_bit(carry, m_carry, "carry");
			check_word(io, m_hold, "io word");
			check_word(ctr, m_ctr, "counter");
			check_word(lo, m_lo, "control low");
			check_word(hi, m_hi, "control high");
		end
	end

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick

	task automatic rand_step();
		logic [31:0] x;
		logic [31:0] d;
		x = next_rand();
		d = next_rand();
		s1 = aws_pkg::aws_sel1_t'(x[2:0]);
		s2 = aws_pkg::aws_sel2_t'(x[5:3]);
		op = aws_pkg::aws_op_t'(x[8:6]);
		dst = aws_pkg::aws_dest_t'(4'(x[12:9] % 9));
		sh = aws_pkg::aws_shift_t'(3'(x[15:13] % 5));
		{fill, mode, ptr_load, bus_en} = x[19:16];
		{wide_next, little_next, bus_next} = {d[7:0], x[27:20], d[31:16]};
		xlat_word = d[23:8];
		tick();
	endtask : rand_step

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial
	begin
		repeat (16) tick();
		rst_b = 1'b1;
		// Fill both files so that later reads are defined
		ptr_load = 1'b1;
		for (int i = 0; i < 290; i++)
		begin
			wide_next = 8'(i);
			little_next = 8'(i - 257);
			bus_next = 16'(next_rand() >> 8);
			dst = i < 257 ? aws_pkg::AWS_DST_BIG_FILE : aws_pkg::AWS_DST_LIT_FILE;
			tick();
		end
		// Every shift code except none, with known pair contents, loaded back to back
		for (int k = 1; k < 5; k++)
		begin
			bus_next = 16'h8001;
			dst = aws_pkg::AWS_DST_SHIFT_STORE;
			sh = aws_pkg::AWS_SH_NONE;
			fill = 1'b1;
			tick();
			bus_next = 16'h4002;
			dst = aws_pkg::AWS_DST_SHIFT_EXT;
			tick();
			dst = aws_pkg::AWS_DST_NONE;
			sh = aws_pkg::aws_shift_t'(k);
			tick();
			s1 = aws_pkg::AWS_S1_SHIFT_STORE;
			s2 = aws_pkg::AWS_S2_SHIFT_EXT;
			op = aws_pkg::AWS_OP_ADD;
			sh = aws_pkg::AWS_SH_NONE;
			tick();
			s1 = aws_pkg::AWS_S1_BUS;
			op = aws_pkg::AWS_OP_PASS_A;
		end
		repeat (3000) rand_step();
		dst = aws_pkg::AWS_DST_NONE;
		ptr_load = 1'b0;
		repeat (3) tick();
		rst_b = 1'b0;
		repeat (3) tick();
		rst_b = 1'b1;
		repeat (500) rand_step();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
